// ===== sfp_pkg.sv
/*
  Shared constants and types of the serial flash pin interface.
  Assumes a 50 MHz system clock and a mode 0 serial link.
*/
// What this block does
// - Single output bits change on clock falling edge.
// - Dual reads drive two lines per falling edge.
// - Output lines float while chip select is high.
// - Protect pin low locks status when unlocked-quad.
// - Quad enabled makes protect pin data line two.
// - Quad disabled makes fourth pin the pause input.
// - Quad enabled makes pause pin data line three.
// - Pause freezes the sequence, resumes where stopped.
// - Controller pauses only while chip select low.
// - Pause starts on pause pin falling, clock low.
// - Pause ends on pause pin rising, clock low.
// - Input line sampled on clock rising edges, except in read data phase.
// - Deselected device ignores input; frame needs select.
// - Quad commands turn all four pins into data.
package sfp_pkg;

  typedef enum logic [1:0] {
    SFP_W_SINGLE,
    SFP_W_DUAL,
    SFP_W_QUAD
  } sfp_width_e;

  localparam int         SFP_MCLK_NS     = 20;
  localparam int         SFP_SCK_HALF_NS = 80;
  localparam int         SFP_DIV_HALF    = SFP_SCK_HALF_NS / SFP_MCLK_NS;
  localparam logic [3:0] SFP_BYTE_BITS   = 4'h8;
  localparam logic [3:0] SFP_CMD_LAST    = 4'h7;
  localparam logic       SFP_LOCK_HI     = 1'b0;
  localparam logic       SFP_LOCK_LO     = 1'b1;
  localparam int         SFP_IO_W        = 4;
  localparam int         SFP_IO_SO       = 1;
  localparam int         SFP_IO_PROT     = 2;
  localparam int         SFP_IO_PAUSE    = 3;

  function automatic logic [3:0] sfp_bits(input sfp_width_e w);
    case (w)
      SFP_W_DUAL: return 4'h2;
      SFP_W_QUAD: return 4'h4;
      default:    return 4'h1;
    endcase
  endfunction : sfp_bits

endpackage : sfp_pkg

// ===== sfp_link_if.sv
/*
  Pin bundle between the serial controller and the flash device end.
  Resolves the four shared data pins; an undriven pin reads high.
*/
`timescale 1ns/100ps
`default_nettype none
interface sfp_link_if;
  logic       sck;
  logic       cs_n;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io;

  // Pull-ups stand in for the external resistors on the pins.
  assign io = (dev_io_oe & dev_io_out)
            | (~dev_io_oe & host_io_oe & host_io_out)
            | (~dev_io_oe & ~host_io_oe);

  modport dev (input sck, input cs_n, input io,
               output dev_io_out, output dev_io_oe);
  modport host (output sck, output cs_n, output host_io_out,
                output host_io_oe, input io);
endinterface : sfp_link_if
`default_nettype wire

// ===== sfp_flash_end.sv
/*
  Device end: pin logic of the serial flash, clocked by the link clock.
  Assumes mode 0 framing and a user side on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sfp_flash_end (
  // System side
  input  wire logic               mclk_in,
  input  wire logic               rst_in,
  // Link
  sfp_link_if.dev                 link,
  // Status bits
  input  wire logic               quad_io_enable_in,
  input  wire logic               status_protect_hi_in,
  input  wire logic               status_protect_lo_in,
  // Transfer setup
  input  wire sfp_pkg::sfp_width_e width_in,
  input  wire logic               read_in,
  input  wire logic [7:0]         tx_byte_in,
  // Results
  output logic                    tx_take_out,
  output logic [7:0]              rx_byte_out,
  output logic                    rx_valid_out,
  output logic                    wp_block_out,
  output logic                    paused_out
);
  import sfp_pkg::*;

  // Link domain. The link clock stops between frames, so these carry
  // power-up values instead of a reset they could never see.
  logic       qe_s1_reg  = 1'b0;
  logic       qe_s2_reg  = 1'b0;
  logic       rd_s1_reg  = 1'b0;
  logic       rd_s2_reg  = 1'b0;
  sfp_width_e wd_s1_reg  = SFP_W_SINGLE;
  sfp_width_e wd_s2_reg  = SFP_W_SINGLE;
  logic       rx_tgl_reg = 1'b0;
  logic       rx_tgl_next;
  logic       tx_tgl_reg = 1'b0;
  logic       tx_tgl_next;
  logic [7:0] rx_hold_reg = 8'h00;
  logic [7:0] rx_hold_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       cmd_done_reg;
  logic       cmd_done_next;
  logic [7:0] in_sr_reg;
  logic [7:0] in_sr_next;
  logic [3:0] ocnt_reg;
  logic [3:0] ocnt_next;
  logic [7:0] out_sr_reg;
  logic [7:0] out_sr_next;
  logic       paused;
  logic [3:0] bits;
  logic [3:0] lanes;
  logic [3:0] sum;
  logic [7:0] shifted;
  logic       drive;
  logic [3:0] oe_mask;

  // System domain.
  logic [7:0] tx_hold_reg;
  logic [7:0] tx_hold_next;
  logic [2:0] txt_s_reg;
  logic [2:0] rxt_s_reg;
  logic [1:0] cs_s_reg;
  logic [1:0] wp_s_reg;
  logic [1:0] ho_s_reg;
  logic [7:0] rx_byte_reg;
  logic [7:0] rx_byte_next;
  logic       rx_valid_reg;
  logic       tx_take_reg;
  logic       wp_block_reg;
  logic       paused_reg;

  // Pause is decoded from quad mode off and the pause pin low; chip select is not part of it.
  assign paused = ~qe_s2_reg & ~link.io[SFP_IO_PAUSE];
  assign bits   = sfp_bits(wd_s2_reg);
  assign sum    = cnt_reg + bits;

  always_comb
  begin
    case (wd_s2_reg)
      SFP_W_DUAL: lanes = {2'b00, link.io[1:0]};
      SFP_W_QUAD: lanes = link.io;
      default:    lanes = {3'b000, link.io[0]};
    endcase
  end

  always_comb
  begin
    case (wd_s2_reg)
      SFP_W_DUAL: shifted = {in_sr_reg[5:0], lanes[1:0]};
      SFP_W_QUAD: shifted = {in_sr_reg[3:0], lanes};
      default:    shifted = {in_sr_reg[6:0], lanes[0]};
    endcase
  end

  always_comb
  begin
    cnt_next      = cnt_reg;
    cmd_done_next = cmd_done_reg;
    in_sr_next    = in_sr_reg;
    rx_hold_next  = rx_hold_reg;
    rx_tgl_next   = rx_tgl_reg;
    if (!paused)
    begin
      if (!cmd_done_reg)
      begin
        in_sr_next = {in_sr_reg[6:0], link.io[0]};
        cnt_next   = cnt_reg + 4'h1;
        if (cnt_reg == SFP_CMD_LAST)
        begin
          cmd_done_next = 1'b1;
          cnt_next      = 4'h0;
          rx_hold_next  = {in_sr_reg[6:0], link.io[0]};
          rx_tgl_next   = ~rx_tgl_reg;
        end
      end
      else if (!rd_s2_reg)
      begin
        in_sr_next = shifted;
        cnt_next   = sum;
        if (sum == SFP_BYTE_BITS)
        begin
          cnt_next     = 4'h0;
          rx_hold_next = shifted;
          rx_tgl_next  = ~rx_tgl_reg;
        end
      end
    end
  end

  // Chip select high clears the frame without needing a clock edge.
  always_ff @(posedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      cnt_reg      <= 4'h0;
      cmd_done_reg <= 1'b0;
      in_sr_reg    <= 8'h00;
    end
    else
    begin
      cnt_reg      <= cnt_next;
      cmd_done_reg <= cmd_done_next;
      in_sr_reg    <= in_sr_next;
    end
  end

  always_ff @(posedge link.sck)
  begin
    qe_s1_reg   <= quad_io_enable_in;
    qe_s2_reg   <= qe_s1_reg;
    rd_s1_reg   <= read_in;
    rd_s2_reg   <= rd_s1_reg;
    wd_s1_reg   <= width_in;
    wd_s2_reg   <= wd_s1_reg;
    rx_hold_reg <= rx_hold_next;
    rx_tgl_reg  <= rx_tgl_next;
  end

  always_comb
  begin
    ocnt_next   = ocnt_reg;
    out_sr_next = out_sr_reg;
    tx_tgl_next = tx_tgl_reg;
    if (cmd_done_reg && rd_s2_reg && !paused)
    begin
      if (ocnt_reg == SFP_BYTE_BITS || ocnt_reg == 4'h0)
      begin
        out_sr_next = tx_hold_reg;
        ocnt_next   = bits;
        tx_tgl_next = ~tx_tgl_reg;
      end
      else
      begin
        out_sr_next = out_sr_reg << bits;
        ocnt_next   = ocnt_reg + bits;
      end
    end
  end

  always_ff @(negedge link.sck or posedge link.cs_n)
  begin
    if (link.cs_n)
    begin
      ocnt_reg   <= 4'h0;
      out_sr_reg <= 8'h00;
    end
    else
    begin
      ocnt_reg   <= ocnt_next;
      out_sr_reg <= out_sr_next;
    end
  end

  always_ff @(negedge link.sck)
  begin
    tx_tgl_reg <= tx_tgl_next;
  end

  assign drive = ~link.cs_n & cmd_done_reg & rd_s2_reg & ~paused
               & (ocnt_reg != 4'h0);

  always_comb
  begin
    case (wd_s2_reg)
      SFP_W_DUAL: oe_mask = 4'b0011;
      SFP_W_QUAD: oe_mask = {qe_s2_reg, qe_s2_reg, 2'b11};
      default:    oe_mask = 4'b0010;
    endcase
  end

  assign link.dev_io_oe  = drive ? oe_mask : 4'b0000;
  assign link.dev_io_out = (wd_s2_reg == SFP_W_SINGLE)
                         ? {2'b00, out_sr_reg[7], 1'b0}
                         : (wd_s2_reg == SFP_W_DUAL)
                         ? {2'b00, out_sr_reg[7:6]}
                         : out_sr_reg[7:4];

  // Rx bytes cross on a toggle and are copied without further sync.
  // The next tx byte is taken while tx_take_out stands, once put.
  always_comb
  begin
    rx_byte_next = rx_byte_reg;
    tx_hold_next = tx_hold_reg;
    if (rxt_s_reg[2] != rxt_s_reg[1])
      rx_byte_next = rx_hold_reg;
    if (cs_s_reg[1] || tx_take_reg)
      tx_hold_next = tx_byte_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      txt_s_reg    <= 3'b000;
      rxt_s_reg    <= 3'b000;
      cs_s_reg     <= 2'b11;
      wp_s_reg     <= 2'b11;
      ho_s_reg     <= 2'b11;
      rx_byte_reg  <= 8'h00;
      tx_hold_reg  <= 8'h00;
      rx_valid_reg <= 1'b0;
      tx_take_reg  <= 1'b0;
      wp_block_reg <= 1'b0;
      paused_reg   <= 1'b0;
    end
    else
    begin
      txt_s_reg    <= {txt_s_reg[1:0], tx_tgl_reg};
      rxt_s_reg    <= {rxt_s_reg[1:0], rx_tgl_reg};
      cs_s_reg     <= {cs_s_reg[0], link.cs_n};
      wp_s_reg     <= {wp_s_reg[0], link.io[SFP_IO_PROT]};
      ho_s_reg     <= {ho_s_reg[0], link.io[SFP_IO_PAUSE]};
      rx_byte_reg  <= rx_byte_next;
      tx_hold_reg  <= tx_hold_next;
      rx_valid_reg <= rxt_s_reg[2] != rxt_s_reg[1];
      tx_take_reg  <= ~cs_s_reg[1] & (txt_s_reg[2] != txt_s_reg[1]);
      wp_block_reg <= ~quad_io_enable_in
                    & (status_protect_hi_in == SFP_LOCK_HI)
                    & (status_protect_lo_in == SFP_LOCK_LO)
                    & ~wp_s_reg[1];
      paused_reg   <= ~quad_io_enable_in & ~cs_s_reg[1]
                    & ~ho_s_reg[1];
    end
  end

  assign tx_take_out  = tx_take_reg;
  assign rx_byte_out  = rx_byte_reg;
  assign rx_valid_out = rx_valid_reg;
  assign wp_block_out = wp_block_reg;
  assign paused_out   = paused_reg;

endmodule : sfp_flash_end
`default_nettype wire

// ===== sfp_ctrl_end.sv
/*
  Controller end: drives the link clock by a divider and runs frames.
  Assumes the device end is wired through the link interface.
*/
`timescale 1ns/100ps
`default_nettype none
module sfp_ctrl_end (
  // System side
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  // Link
  sfp_link_if.host                 link,
  // Frame request
  input  wire logic                start_in,
  input  wire logic [7:0]          cmd_in,
  input  wire sfp_pkg::sfp_width_e width_in,
  input  wire logic                read_in,
  input  wire logic [7:0]          len_in,
  input  wire logic [7:0]          wr_byte_in,
  // Pin controls
  input  wire logic                hold_req_in,
  input  wire logic                quad_io_enable_in,
  input  wire logic                wp_n_in,
  // Results
  output logic                     busy_out,
  output logic                     wr_take_out,
  output logic [7:0]               rd_byte_out,
  output logic                     rd_valid_out
);
  import sfp_pkg::*;

  typedef enum logic [1:0] {SFP_H_IDLE, SFP_H_CMD, SFP_H_DATA,
                            SFP_H_END} sfp_hstate_e;

  sfp_hstate_e state_reg, state_next;
  sfp_width_e  wd_reg, wd_next;
  logic [2:0]  div_reg, div_next;
  logic        sck_reg, sck_next;
  logic        cs_n_reg, cs_n_next;
  logic        hold_n_reg, hold_n_next;
  logic        rd_reg, rd_next;
  logic        last_reg, last_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [7:0]  len_reg, len_next;
  logic [7:0]  sr_reg, sr_next;
  logic [7:0]  in_reg, in_next;
  logic [7:0]  rbyte_reg, rbyte_next;
  logic        rvalid_reg, rvalid_next;
  logic        take_reg, take_next;
  logic [3:0]  io_s1_reg, io_s2_reg;
  logic        tick;
  logic [3:0]  bits;
  logic [3:0]  sum;
  logic [7:0]  shifted;
  logic        wdata;

  assign tick  = div_reg == 3'(SFP_DIV_HALF - 1);
  assign bits  = (state_reg == SFP_H_CMD) ? 4'h1 : sfp_bits(wd_reg);
  assign sum   = cnt_reg + bits;
  assign wdata = (state_reg == SFP_H_DATA) & ~rd_reg;

  always_comb
  begin
    case (wd_reg)
      SFP_W_DUAL: shifted = {in_reg[5:0], io_s2_reg[1:0]};
      SFP_W_QUAD: shifted = {in_reg[3:0], io_s2_reg};
      default:    shifted = {in_reg[6:0], io_s2_reg[SFP_IO_SO]};
    endcase
  end

  always_comb
  begin
    state_next  = state_reg;
    wd_next     = wd_reg;
    div_next    = tick ? 3'h0 : div_reg + 3'h1;
    sck_next    = sck_reg;
    cs_n_next   = cs_n_reg;
    hold_n_next = hold_n_reg;
    rd_next     = rd_reg;
    last_next   = last_reg;
    cnt_next    = cnt_reg;
    len_next    = len_reg;
    sr_next     = sr_reg;
    in_next     = in_reg;
    rbyte_next  = rbyte_reg;
    rvalid_next = 1'b0;
    take_next   = 1'b0;
    case (state_reg)
      SFP_H_IDLE:
      begin
        hold_n_next = 1'b1;
        if (start_in)
        begin
          state_next = SFP_H_CMD;
          cs_n_next  = 1'b0;
          sr_next    = cmd_in;
          wd_next    = width_in;
          rd_next    = read_in;
          len_next   = len_in;
          cnt_next   = 4'h0;
          last_next  = 1'b0;
          div_next   = 3'h0;
        end
      end
      SFP_H_CMD, SFP_H_DATA:
      begin
        if (tick)
        begin
          // Pause edges only with the clock low inside a frame.
          if (!sck_reg && hold_n_reg && hold_req_in
              && !quad_io_enable_in)
            hold_n_next = 1'b0;
          else if (!sck_reg && !hold_n_reg && !hold_req_in)
            hold_n_next = 1'b1;
          else if (hold_n_reg && !sck_reg)
          begin
            sck_next = 1'b1;
            cnt_next = sum;
            if (state_reg == SFP_H_DATA && rd_reg)
            begin
              in_next = shifted;
              if (sum == SFP_BYTE_BITS)
              begin
                rbyte_next  = shifted;
                rvalid_next = 1'b1;
              end
            end
            if (sum == SFP_BYTE_BITS)
            begin
              if (state_reg == SFP_H_DATA)
                len_next = len_reg - 8'h01;
              last_next = (state_reg == SFP_H_CMD) ? (len_reg == 8'h00)
                                                   : (len_reg == 8'h01);
            end
          end
          else if (hold_n_reg)
          begin
            sck_next = 1'b0;
            if (last_reg)
              state_next = SFP_H_END;
            else if (cnt_reg == SFP_BYTE_BITS)
            begin
              state_next = SFP_H_DATA;
              cnt_next   = 4'h0;
              sr_next    = wr_byte_in;
              take_next  = ~rd_reg;
            end
            else
              sr_next = sr_reg << bits;
          end
        end
      end
      SFP_H_END:
      begin
        if (tick)
        begin
          cs_n_next  = 1'b1;
          state_next = SFP_H_IDLE;
        end
      end
      default: state_next = SFP_H_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      state_reg  <= SFP_H_IDLE;
      wd_reg     <= SFP_W_SINGLE;
      div_reg    <= 3'h0;
      sck_reg    <= 1'b0;
      cs_n_reg   <= 1'b1;
      hold_n_reg <= 1'b1;
      rd_reg     <= 1'b0;
      last_reg   <= 1'b0;
      cnt_reg    <= 4'h0;
      len_reg    <= 8'h00;
      sr_reg     <= 8'h00;
      in_reg     <= 8'h00;
      rbyte_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
      take_reg   <= 1'b0;
      io_s1_reg  <= 4'hF;
      io_s2_reg  <= 4'hF;
    end
    else
    begin
      state_reg  <= state_next;
      wd_reg     <= wd_next;
      div_reg    <= div_next;
      sck_reg    <= sck_next;
      cs_n_reg   <= cs_n_next;
      hold_n_reg <= hold_n_next;
      rd_reg     <= rd_next;
      last_reg   <= last_next;
      cnt_reg    <= cnt_next;
      len_reg    <= len_next;
      sr_reg     <= sr_next;
      in_reg     <= in_next;
      rbyte_reg  <= rbyte_next;
      rvalid_reg <= rvalid_next;
      take_reg   <= take_next;
      io_s1_reg  <= link.io;
      io_s2_reg  <= io_s1_reg;
    end
  end

  // With quad off the upper pins are protect and pause controls.
  always_comb
  begin
    link.host_io_oe  = 4'b0000;
    link.host_io_out = 4'b0000;
    if (!quad_io_enable_in)
    begin
      link.host_io_oe[3:2]  = 2'b11;
      link.host_io_out[3:2] = {hold_n_reg, wp_n_in};
    end
    if (state_reg == SFP_H_CMD || (wdata && wd_reg == SFP_W_SINGLE))
    begin
      link.host_io_oe[0]  = 1'b1;
      link.host_io_out[0] = sr_reg[7];
    end
    else if (wdata && wd_reg == SFP_W_DUAL)
    begin
      link.host_io_oe[1:0]  = 2'b11;
      link.host_io_out[1:0] = sr_reg[7:6];
    end
    else if (wdata && quad_io_enable_in)
    begin
      link.host_io_oe  = 4'b1111;
      link.host_io_out = sr_reg[7:4];
    end
  end

  assign link.sck     = sck_reg;
  assign link.cs_n    = cs_n_reg;
  assign busy_out     = state_reg != SFP_H_IDLE;
  assign wr_take_out  = take_reg;
  assign rd_byte_out  = rbyte_reg;
  assign rd_valid_out = rvalid_reg;

endmodule : sfp_ctrl_end
`default_nettype wire

// ===== sfp_link_sva.sv
/*
  Checker for the pins between controller end and device end.
  Assumes plain copies of the link bundle signals and the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sfp_link_sva (
  // System side
  input wire logic       mclk_in,
  input wire logic       rst_in,
  // Link bundle
  input wire logic       sck,
  input wire logic       cs_n,
  input wire logic [3:0] host_io_out,
  input wire logic [3:0] host_io_oe,
  input wire logic [3:0] dev_io_out,
  input wire logic [3:0] dev_io_oe,
  input wire logic [3:0] io
);
  // The link clock comes from an mclk divider, so mclk sees every edge.
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_float_desel;
    cs_n |-> dev_io_oe == 4'h0;
  endproperty
  a_float_desel: assert property (p_float_desel)
    else $error("device drives while deselected");
  property p_out_fall;
    !cs_n && sck && $past(sck) && !$past(cs_n)
      |-> $stable(dev_io_out & dev_io_oe);
  endproperty
  a_out_fall: assert property (p_out_fall)
    else $error("device output moved while link clock high");
  property p_si_setup;
    !cs_n && sck && $past(sck) |-> $stable(host_io_out[0]);
  endproperty
  a_si_setup: assert property (p_si_setup)
    else $error("input line moved while link clock high");
  property p_hold_edge;
    !cs_n && host_io_oe[3] && $changed(host_io_out[3]) |-> !sck;
  endproperty
  a_hold_edge: assert property (p_hold_edge)
    else $error("pause pin moved while link clock high");
  property p_hold_sel;
    host_io_oe[3] && !host_io_out[3] |-> !cs_n;
  endproperty
  a_hold_sel: assert property (p_hold_sel)
    else $error("pause began while deselected");
  property p_pause_float;
    !cs_n && host_io_oe[3] && !io[3] |-> dev_io_oe == 4'h0;
  endproperty
  a_pause_float: assert property (p_pause_float)
    else $error("device drives while paused");
  property p_pause_freeze;
    !cs_n && host_io_oe[3] && !host_io_oe[0] && !io[3] ##1 !io[3]
      |-> !sck && $stable(sck);
  endproperty
  a_pause_freeze: assert property (p_pause_freeze)
    else $error("link clock ran while paused");
  property p_upper_clash;
    host_io_oe[3:2] != 2'h0 |-> (dev_io_oe[3:2] & host_io_oe[3:2]) == 2'h0;
  endproperty
  a_upper_clash: assert property (p_upper_clash)
    else $error("device drove a control pin");
endmodule : sfp_link_sva
`default_nettype wire

// ===== serial_flash_pin_interface_bench.sv
/*
  Self-checking bench: controller end and device end joined by the link.
  Assumes the design files and the link checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_flash_pin_interface_bench;
  import sfp_pkg::*;
  logic       mclk_in, rst_in, qe, sp_hi, sp_lo, wp_n, rd, start, hold_req;
  logic       tx_take, rx_valid, wp_block, paused, busy, wr_take, rd_valid;
  sfp_width_e width;
  logic [7:0] cmd, len, tx_byte, wr_byte, rx_byte, rd_byte;
  logic [7:0] rxq[$];
  logic [7:0] rdq[$];
  logic [4:0] wpt [5] = '{5'h05, 5'h06, 5'h0C, 5'h00, 5'h14};
  int         tx_idx, wr_idx, fail_count, compares, k;

  sfp_link_if u_sfp_link_if ();
  sfp_flash_end u_sfp_flash_end (
    .mclk_in(mclk_in), .rst_in(rst_in), .link(u_sfp_link_if.dev),
    .quad_io_enable_in(qe), .status_protect_hi_in(sp_hi),
    .status_protect_lo_in(sp_lo), .width_in(width), .read_in(rd),
    .tx_byte_in(tx_byte), .tx_take_out(tx_take), .rx_byte_out(rx_byte),
    .rx_valid_out(rx_valid), .wp_block_out(wp_block),
    .paused_out(paused));
  sfp_ctrl_end u_sfp_ctrl_end (
    .mclk_in(mclk_in), .rst_in(rst_in), .link(u_sfp_link_if.host),
    .start_in(start), .cmd_in(cmd), .width_in(width), .read_in(rd),
    .len_in(len), .wr_byte_in(wr_byte), .hold_req_in(hold_req),
    .quad_io_enable_in(qe), .wp_n_in(wp_n), .busy_out(busy),
    .wr_take_out(wr_take), .rd_byte_out(rd_byte), .rd_valid_out(rd_valid));
  sfp_link_sva u_sfp_link_sva (
    .mclk_in(mclk_in), .rst_in(rst_in), .sck(u_sfp_link_if.sck),
    .cs_n(u_sfp_link_if.cs_n), .host_io_out(u_sfp_link_if.host_io_out),
    .host_io_oe(u_sfp_link_if.host_io_oe),
    .dev_io_out(u_sfp_link_if.dev_io_out),
    .dev_io_oe(u_sfp_link_if.dev_io_oe), .io(u_sfp_link_if.io));

  function automatic logic [7:0] pat(input int i);
    return 8'h5A + 8'h11 * i[7:0];
  endfunction : pat

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // Each taken byte is replaced by the next one of the pattern.
  always @(negedge mclk_in)
  begin
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (rd_valid === 1'b1) rdq.push_back(rd_byte);
    if (tx_take === 1'b1)
    begin
      tx_idx++;
      tx_byte <= pat(tx_idx);
    end
    if (wr_take === 1'b1)
    begin
      wr_idx++;
      wr_byte <= pat(wr_idx);
    end
  end

  task automatic frame(input sfp_width_e w, input logic r,
                       input logic [7:0] n, input logic hld);
    int   i;
    logic s;
    @(negedge mclk_in);
    width = w;
    rd = r;
    len = n;
    qe = (w == SFP_W_QUAD);
    cmd = cmd + 8'h27;
    tx_idx = 0;
    wr_idx = 0;
    tx_byte = pat(0);
    wr_byte = pat(0);
    rxq.delete();
    rdq.delete();
    // Mode bits reach the link side within the first command edges.
    repeat (4) @(negedge mclk_in);
    start = 1'b1;
    @(negedge mclk_in);
    start = 1'b0;
    if (hld)
    begin
      repeat (100) @(negedge mclk_in);
      hold_req = 1'b1;
      for (i = 0; i < 40 && paused !== 1'b1; i++) @(negedge mclk_in);
      s = u_sfp_link_if.sck;
      repeat (16) @(negedge mclk_in);
      if (qe)
        chk("paused", 8'h00, {7'h00, paused});
      else
      begin
        chk("paused", 8'h01, {7'h00, paused});
        chk("pause_sck", {7'h00, s}, {7'h00, u_sfp_link_if.sck});
        chk("pause_oe", 8'h00, {4'h0, u_sfp_link_if.dev_io_oe});
      end
      hold_req = 1'b0;
      repeat (40) @(negedge mclk_in);
      chk("resumed", 8'h00, {7'h00, paused});
    end
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge mclk_in);
    chk("busy", 8'h00, {7'h00, busy});
    repeat (8) @(negedge mclk_in);
    chk("rx_count", r ? 8'h01 : n + 8'h01, 8'(rxq.size()));
    chk("rx_cmd", cmd, rxq.size() > 0 ? rxq[0] : 8'hXX);
    chk("rd_count", r ? n : 8'h00, 8'(rdq.size()));
    chk("so_idle", 8'h01, {7'h00, u_sfp_link_if.io[1]});
    for (i = 0; i < n; i++)
      if (r)
        chk("rd_data", pat(i), i < rdq.size() ? rdq[i] : 8'hXX);
      else
        chk("rx_data", pat(i), i < rxq.size() - 1 ? rxq[i + 1] : 8'hXX);
  endtask : frame

  initial
  begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  // About 13 frames of some 160 cycles each; the limit is near ten times that.
  initial
  begin
    repeat (20000) @(posedge mclk_in);
    fail_count++;
    end_sim();
  end

  initial
  begin
    rst_in = 1'b1;
    {qe, sp_hi, sp_lo, wp_n, rd, start, hold_req} = 7'h08;
    width = SFP_W_SINGLE;
    {cmd, len, tx_byte, wr_byte} = 32'h0;
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    for (k = 0; k < 6; k++)
      frame(sfp_width_e'(k / 2), k[0], 8'h03, 1'b0);
    frame(SFP_W_SINGLE, 1'b1, 8'h02, 1'b1);
    frame(SFP_W_QUAD, 1'b1, 8'h02, 1'b1);
    for (k = 0; k < 5; k++)
    begin
      {sp_hi, sp_lo, wp_n} = wpt[k][3:1];
      frame(wpt[k][4] ? SFP_W_QUAD : SFP_W_SINGLE, 1'b0, 8'h00, 1'b0);
      chk("wp_block", {7'h00, wpt[k][0]}, {7'h00, wp_block});
    end
    end_sim();
  end
endmodule : serial_flash_pin_interface_bench
`default_nettype wire
